/* rtl/vpc_pkg.sv */
// Types shared by the vector placement control block
package vpc_pkg;
   typedef logic [7:0] vpc_byte_t;
   typedef logic [1:0] vpc_fuse_t;
endpackage

/* rtl/vpc_regs.svh */
// Offsets, bit positions, reset values and timing counts of the control reg
`ifndef VPC_REGS_SVH
`define VPC_REGS_SVH
`define VPC_DS_OFS        8'h55
`define VPC_IO_BIAS       8'h20
`define VPC_IO_OFS        (`VPC_DS_OFS - `VPC_IO_BIAS)
`define VPC_RESET         8'h00
`define VPC_BIT_VEC_ARM   0
`define VPC_BIT_VEC_SEL   1
`define VPC_BIT_PU_OFF    4
`define VPC_BIT_BSD_ARM   5
`define VPC_BIT_BSD       6
`define VPC_ARM_CYCLES    3'h4
`define VPC_HOLD_CYCLES   2'h2
`define VPC_BSD_CYCLES    3'h3
`define VPC_BSD_TOTAL     3'h6
`define VPC_VEC_INT0_OFS  2
`endif

/* rtl/vpc_top.sv */
// Control register: vector placement, timed unlocks, pull-up disable
`timescale 1ns/1ps
`include "vpc_regs.svh"

// Contract
// - Vector base is flash start when select is zero, boot start if one.
// - Boot start address follows the boot-size fuse setting.
// - Two-kilobyte boot gives start 0x1C00 and first external vector 0x1C02.
// - Interrupts blocked from arming until after the instruction after select write.
// - Without select write, interrupts stay blocked four cycles then release.
// - Automatic blocking never touches the global interrupt enable bit.
// - Change-enable clears four cycles after write or at the select write.
// - Boot vectors with app lock programmed block interrupts in application code.
// - App vectors with boot lock programmed block interrupts in boot code.
// - Brown-out sleep-disable takes effect three cycles after it is set.
// - Brown-out is turned off only if sleep executes while disable is active.
// - Brown-out sleep-disable bit clears itself three cycles after being set.
// - Pull-up disable forces every port pull-up off, even for pattern 0b01.
// - Register decodes at data offset 0x55 and I/O offset 0x35.
module vpc_top #(
   parameter int ADDR_W          = 13,
   parameter int FLASH_WORDS     = 8192,
   parameter int MIN_BOOT_WORDS  = 128,
   parameter int PORT_PINS       = 8
) (
   input  wire logic                  sys_clk,
   input  wire logic                  resetn,
   input  wire logic [7:0]            ds_addr,
   input  wire logic                  ds_wr,
   input  wire logic [5:0]            io_addr,
   input  wire logic                  io_wr,
   input  wire vpc_pkg::vpc_byte_t    wdata,
   output      vpc_pkg::vpc_byte_t    rdata,
   input  wire vpc_pkg::vpc_fuse_t    boot_size_fuse,
   input  wire logic                  app_boot_lock_bit,
   input  wire logic                  boot_boot_lock_bit,
   input  wire logic                  exec_in_boot,
   input  wire logic                  sleep_exec,
   input  wire logic [PORT_PINS-1:0]  pin_direction_bit,
   input  wire logic [PORT_PINS-1:0]  pin_output_bit,
   output      logic [ADDR_W-1:0]     vector_base,
   output      logic [ADDR_W-1:0]     ext_int0_vector,
   output      logic                  irq_block,
   output      logic                  brownout_sleep_active,
   output      logic                  brownout_sleep_off,
   output      logic                  pullup_disable,
   output      logic [PORT_PINS-1:0]  pullup_en
);

   // Refuse sizes the address arithmetic cannot serve
   if (FLASH_WORDS != (1 << ADDR_W) || MIN_BOOT_WORDS * 8 > FLASH_WORDS ||
       PORT_PINS < 1) begin : g_bad_size
      $error("vpc_top: flash size, address width or pin count unusable");
   end

   logic       vec_arm_reg, vec_arm_next;
   logic       vec_sel_reg, vec_sel_next;
   logic       pu_off_reg;
   logic       bsd_arm_reg, bsd_arm_next;
   logic [2:0] arm_cnt_reg, arm_cnt_next;
   logic [1:0] hold_cnt_reg, hold_cnt_next;
   logic [2:0] bse_cnt_reg, bse_cnt_next;
   logic [2:0] bsd_cnt_reg, bsd_cnt_next;

   // Both address spaces reach the same byte
   wire hit_ds = ds_wr && (ds_addr == `VPC_DS_OFS);
   wire hit_io = io_wr && (io_addr == 6'(`VPC_IO_OFS));
   wire wr_hit = hit_ds || hit_io;

   // Unlock decode; a write carrying the enable bit re-arms instead
   wire vec_arm_wr = wr_hit && wdata[`VPC_BIT_VEC_ARM];
   wire vec_sel_wr = wr_hit && !wdata[`VPC_BIT_VEC_ARM] &&
                     vec_arm_reg;
   wire bsd_arm_wr = wr_hit && wdata[`VPC_BIT_BSD] && wdata[`VPC_BIT_BSD_ARM];
   wire bsd_set    = wr_hit && wdata[`VPC_BIT_BSD] &&
                     !wdata[`VPC_BIT_BSD_ARM] && bsd_arm_reg;

   // Change-enable window: four cycles, cut short by the select write
   always_comb begin
      vec_arm_next  = vec_arm_reg;
      arm_cnt_next  = arm_cnt_reg;
      vec_sel_next  = vec_sel_reg;
      hold_cnt_next = (hold_cnt_reg != 2'h0) ? hold_cnt_reg - 2'h1 : 2'h0;
      if (vec_arm_wr) begin
         vec_arm_next = 1'b1;
         arm_cnt_next = `VPC_ARM_CYCLES;
      end else if (vec_sel_wr) begin
         vec_arm_next  = 1'b0;
         arm_cnt_next  = 3'h0;
         vec_sel_next  = wdata[`VPC_BIT_VEC_SEL];
         // Two cycles: the write's own and the instruction after it
         hold_cnt_next = `VPC_HOLD_CYCLES;
      end else if (arm_cnt_reg == 3'h1) begin
         vec_arm_next = 1'b0;
         arm_cnt_next = 3'h0;
      end else if (arm_cnt_reg != 3'h0) begin
         arm_cnt_next = arm_cnt_reg - 3'h1;
      end
   end

   // Sleep-disable: four-cycle enable window, then a six-cycle life
   always_comb begin
      bsd_arm_next = bsd_arm_reg;
      bse_cnt_next = bse_cnt_reg;
      bsd_cnt_next = (bsd_cnt_reg != 3'h0) ? bsd_cnt_reg - 3'h1 : 3'h0;
      if (bsd_arm_wr) begin
         bsd_arm_next = 1'b1;
         bse_cnt_next = `VPC_ARM_CYCLES;
      end else if (bsd_set) begin
         bsd_arm_next = 1'b0;
         bse_cnt_next = 3'h0;
         bsd_cnt_next = `VPC_BSD_TOTAL;
      end else if (bse_cnt_reg == 3'h1) begin
         bsd_arm_next = 1'b0;
         bse_cnt_next = 3'h0;
      end else if (bse_cnt_reg != 3'h0) begin
         bse_cnt_next = bse_cnt_reg - 3'h1;
      end
   end

   // Bit reads one for its first three cycles, then it acts
   wire bsd_bit      = bsd_cnt_reg > `VPC_BSD_CYCLES;
   wire bsd_act_next = (bsd_cnt_next != 3'h0) &&
                       (bsd_cnt_next <= `VPC_BSD_CYCLES);

   // Boot start is flash end minus the fuse-chosen boot size
   wire [ADDR_W:0] boot_words =
      (ADDR_W+1)'(MIN_BOOT_WORDS) << (2'h3 - boot_size_fuse);
   wire [ADDR_W-1:0] boot_start =
      ADDR_W'((ADDR_W+1)'(FLASH_WORDS) - boot_words);
   wire [ADDR_W-1:0] base_next = vec_sel_next ? boot_start : '0;

   // Lock-bit suppression depends on where code runs
   wire lock_block = (vec_sel_next && app_boot_lock_bit && !exec_in_boot) ||
                     (!vec_sel_next && boot_boot_lock_bit && exec_in_boot);
   // Separate line, so the global enable bit elsewhere stays untouched
   wire block_next = vec_arm_next || (hold_cnt_next != 2'h0) || lock_block;

   // Readback; unused bits read zero
   wire [7:0] rd_next = {1'b0, bsd_bit, bsd_arm_reg, pu_off_reg, 2'b00,
                         vec_sel_reg, vec_arm_reg};

   // Pull-ups only for input pins with output bit set, unless disabled
   wire [PORT_PINS-1:0] pu_next =
      ~pin_direction_bit & pin_output_bit & {PORT_PINS{~pu_off_reg}};

   // State flops; reset clears the whole register
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         vec_arm_reg  <= 1'b0;
         vec_sel_reg  <= 1'b0;
         pu_off_reg   <= 1'b0;
         bsd_arm_reg  <= 1'b0;
         arm_cnt_reg  <= 3'h0;
         hold_cnt_reg <= 2'h0;
         bse_cnt_reg  <= 3'h0;
         bsd_cnt_reg  <= 3'h0;
      end else begin
         vec_arm_reg  <= vec_arm_next;
         vec_sel_reg  <= vec_sel_next;
         bsd_arm_reg  <= bsd_arm_next;
         arm_cnt_reg  <= arm_cnt_next;
         hold_cnt_reg <= hold_cnt_next;
         bse_cnt_reg  <= bse_cnt_next;
         bsd_cnt_reg  <= bsd_cnt_next;
         if (wr_hit)
            pu_off_reg <= wdata[`VPC_BIT_PU_OFF];
      end
   end

   // Output flops
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata                 <= `VPC_RESET;
         vector_base           <= '0;
         ext_int0_vector       <= ADDR_W'(`VPC_VEC_INT0_OFS);
         irq_block             <= 1'b0;
         brownout_sleep_active <= 1'b0;
         brownout_sleep_off    <= 1'b0;
         pullup_disable        <= 1'b0;
         pullup_en             <= '0;
      end else begin
         rdata                 <= rd_next;
         vector_base           <= base_next;
         ext_int0_vector       <= base_next + ADDR_W'(`VPC_VEC_INT0_OFS);
         irq_block             <= block_next;
         brownout_sleep_active <= bsd_act_next;
         brownout_sleep_off    <= sleep_exec && brownout_sleep_active;
         pullup_disable        <= pu_off_reg;
         pullup_en             <= pu_next;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   // Vector outputs register from vec_sel_next on the same edge as the select bit, so compare them in the same cycle
   vec_base_a: assert property (
      (vec_sel_reg && $stable(boot_size_fuse)) |-> vector_base == boot_start)
      else $error("vector base not at boot start");
   two_k_a: assert property (
      (vec_sel_reg && boot_size_fuse == 2'b00 && $stable(boot_size_fuse))
      |-> ext_int0_vector == 13'h1c02)
      else $error("first vector not at 0x1c02");
   arm_window_a: assert property (
      (vec_arm_wr && !vec_arm_reg) ##1 (!wr_hit)[*4] |-> ##1 !vec_arm_reg)
      else $error("change enable not cleared after four cycles");
   // An early select write ends the window; its two-cycle hold can lapse before the fourth cycle
   arm_block_a: assert property (
      vec_arm_wr |=> irq_block[*3] ##1 (irq_block || !vec_arm_reg))
      else $error("interrupts not blocked while armed");
   sel_ignored_a: assert property (
      (wr_hit && !vec_arm_reg && !wdata[`VPC_BIT_VEC_ARM])
      |=> $stable(vec_sel_reg))
      else $error("select changed outside window");
   sel_hold_a: assert property (
      vec_sel_wr |=> irq_block ##1 irq_block)
      else $error("block released too early after select write");
   bsd_life_a: assert property (
      bsd_set |=> bsd_bit[*3] ##1 !bsd_bit)
      else $error("sleep disable bit life not three cycles");
   bsd_act_a: assert property (
      bsd_set |=> (!brownout_sleep_active)[*3] ##1 brownout_sleep_active)
      else $error("sleep disable not active after three cycles");
   sleep_off_a: assert property (
      brownout_sleep_off |-> $past(brownout_sleep_active))
      else $error("brown-out turned off without active disable");
   pullup_a: assert property (
      pu_off_reg |=> pullup_en == '0)
      else $error("pull-up left on while disabled");
   io_dec_a: assert property (
      (io_wr && io_addr == 6'h35 && !ds_wr)
      |=> pu_off_reg == $past(wdata[`VPC_BIT_PU_OFF]))
      else $error("io offset not decoded");

endmodule // vpc_top

/* test/vpc_top_bench.sv */
// Self-checking bench for the vector placement control register
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
   $display("BAD t=%0t got %h exp %h", $time, a, e); end end

module vpc_top_bench;
   localparam int RD = 0, VB = 1, EXT = 2, IRQ = 3, ACT = 4, OFF = 5, PUE = 6;
   typedef struct {int due; int sel; logic [15:0] v;} vpc_note_t;
   logic               sys_clk, resetn, ds_wr, io_wr, sleep_exec;
   logic               app_boot_lock_bit, boot_boot_lock_bit, exec_in_boot;
   logic [7:0]         ds_addr, pin_direction_bit, pin_output_bit, pullup_en;
   logic [5:0]         io_addr;
   vpc_pkg::vpc_byte_t wdata, rdata;
   vpc_pkg::vpc_fuse_t boot_size_fuse;
   logic [12:0]        vector_base, ext_int0_vector;
   logic               irq_block, brownout_sleep_active, brownout_sleep_off;
   logic               pullup_disable;
   logic [15:0]        act;
   vpc_note_t          notes[$];
   int                 cyc = 0, errors = 0, checks_done = 0;

   // Every input is driven by the bench; nothing is tied off
   vpc_top vpc_top_inst (.sys_clk, .resetn, .ds_addr, .ds_wr, .io_addr,
      .io_wr, .wdata, .rdata, .boot_size_fuse, .app_boot_lock_bit,
      .boot_boot_lock_bit, .exec_in_boot, .sleep_exec, .pin_direction_bit,
      .pin_output_bit, .vector_base, .ext_int0_vector, .irq_block,
      .brownout_sleep_active, .brownout_sleep_off, .pullup_disable,
      .pullup_en);

   // 125 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Checks at mid-cycle so outputs are settled, oldest note first
   always @(negedge sys_clk) begin
      cyc++;
      while (notes.size() > 0 && notes[0].due <= cyc) begin
         case (notes[0].sel)
            RD: act = {8'h00, rdata};
            VB: act = {3'h0, vector_base};
            EXT: act = {3'h0, ext_int0_vector};
            IRQ: act = {15'h0000, irq_block};
            ACT: act = {15'h0000, brownout_sleep_active};
            OFF: act = {15'h0000, brownout_sleep_off};
            default: act = {7'h00, pullup_disable, pullup_en};
         endcase
         `CHK(act, notes[0].v)
         void'(notes.pop_front());
      end
   end

   // Note an expected value due dt cycles after the current one
   task automatic note(input int dt, input int sel, input logic [15:0] v);
      notes.push_back('{cyc + 1 + dt, sel, v});
   endtask

   // One cycle of bus activity; each call owns exactly one cycle
   task automatic drv(input logic ds, input logic io, input logic [7:0] a,
                      input logic [7:0] d, input logic sl = 1'b0);
      ds_wr <= ds;
      io_wr <= io;
      ds_addr <= a;
      io_addr <= a[5:0];
      wdata <= d;
      sleep_exec <= sl;
      @(posedge sys_clk);
   endtask

   task automatic idle(input int n);
      repeat (n) drv(1'b0, 1'b0, 8'h00, 8'h00);
   endtask

   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Whole run is under two hundred cycles; this bounds a hang
   initial begin
      #80000;
      errors++;
      print_verdict;
   end

   // Main sequence
   initial begin
      logic [7:0] d, dir, po;
      void'($urandom(32'hc34ffc57));
      {ds_wr, io_wr, sleep_exec, resetn, exec_in_boot} = '0;
      {app_boot_lock_bit, boot_boot_lock_bit, boot_size_fuse} = '0;
      {ds_addr, io_addr, wdata, pin_direction_bit, pin_output_bit} = '0;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      note(1, EXT, 16'h0002);
      note(1, RD, 16'h0000);
      idle(3);
      // Select boot vectors on the cycle right after arming
      note(1, IRQ, 16'h0001);
      note(2, VB, 16'h1c00);
      note(2, EXT, 16'h1c02);
      note(3, IRQ, 16'h0001);
      note(3, RD, 16'h0002);
      note(4, IRQ, 16'h0000);
      drv(1'b1, 1'b0, 8'h55, 8'h01);
      drv(1'b1, 1'b0, 8'h55, 8'h02);
      idle(6);
      // Arm through I/O space, let the window lapse, then write late
      note(2, RD, 16'h0003);
      note(4, IRQ, 16'h0001);
      note(5, IRQ, 16'h0000);
      note(6, RD, 16'h0002);
      note(9, VB, 16'h1c00);
      drv(1'b0, 1'b1, 8'h35, 8'h01);
      idle(4);
      drv(1'b0, 1'b1, 8'h35, 8'h00);
      idle(5);
      for (int f = 3; f >= 0; f--) begin
         boot_size_fuse <= f[1:0];
         note(3, VB, 16'(8192 - (128 << (3 - f))));
         idle(4);
      end
      for (int i = 0; i < 2; i++) begin
         {app_boot_lock_bit, exec_in_boot} <= {1'b1, i[0]};
         note(3, IRQ, {15'h0000, !i[0]});
         idle(4);
      end
      // Back to application vectors, select written late in the window
      app_boot_lock_bit <= 1'b0;
      note(4, VB, 16'h0000);
      drv(1'b0, 1'b1, 8'h35, 8'h01);
      idle(2);
      drv(1'b0, 1'b1, 8'h35, 8'h00);
      idle(4);
      for (int i = 0; i < 2; i++) begin
         {boot_boot_lock_bit, exec_in_boot} <= {1'b1, i[0]};
         note(3, IRQ, {15'h0000, i[0]});
         idle(4);
      end
      boot_boot_lock_bit <= 1'b0;
      // Unarmed or misaddressed writes must change nothing
      for (int i = 0; i < 4; i++) begin
         note(2, RD, 16'h0000);
         note(2, IRQ, 16'h0000);
         note(5, ACT, 16'h0000);
         drv(i != 2, i == 2, i == 1 ? 8'h35 : (i == 2 ? 8'h15 : 8'h55),
             i == 0 ? 8'h02 : (i == 3 ? 8'h40 : 8'h01));
         idle(6);
      end
      // Brown-out unlock; one sleep too early, one while active
      note(2, RD, 16'h0020);
      note(3, RD, 16'h0040);
      note(3, OFF, 16'h0000);
      note(4, ACT, 16'h0000);
      note(5, ACT, 16'h0001);
      note(6, RD, 16'h0000);
      note(7, OFF, 16'h0001);
      note(8, ACT, 16'h0000);
      drv(1'b1, 1'b0, 8'h55, 8'h60);
      drv(1'b1, 1'b0, 8'h55, 8'h40);
      drv(1'b0, 1'b0, 8'h00, 8'h00, 1'b1);
      idle(3);
      drv(1'b0, 1'b0, 8'h00, 8'h00, 1'b1);
      idle(4);
      // Random pins and pull-up disable; spare bits must read zero
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom()) & 8'h9c;
         dir = 8'($urandom());
         po = 8'($urandom());
         pin_direction_bit <= dir;
         pin_output_bit <= po;
         note(4, PUE, {7'h00, d[4], ~dir & po & {8{~d[4]}}});
         note(4, RD, {8'h00, d & 8'h10});
         drv(1'b0, 1'b1, 8'h35, d);
         idle(5);
      end
      print_verdict;
   end
endmodule // vpc_top_bench
